// ---- logic/sbdsr_top.sv ----
// Register block of the switch buffer manager: port 2 default tag, three
// ingress rate drop counters, interrupt mask and double-buffered drop status.
// Assumes an AXI4-Lite master on aclk and drop strobes from core logic on aclk.
//
// Function
// [R1] Port 2 default priority, bits 14:12, R/W
// [R2] Port 2 default VLAN ID, bits 11:0
// [R3] One rate drop counter per port
// [R4] Counters reset zero, clear on read
// [R5] Counters saturate at all ones
// [R6] Mask bit 0, reset one, blocks interrupts
// [R7] Mask never touches status capture
// [R8] Two independent capture slots A and B
// [R9] Slot A valid bit 0, clear on read
// [R10] Slot A cause in bits 6:3
// [R11] Source port codes 00, 01, 10
// [R12] Slot B pending bit 7, clear on read
// [R13] Slot B cause in bits 13:10
// [R14] Causes 0000 and 0100 for unknown destination
// [R15] Causes 0001 Red, 1001 Yellow
// [R16] Causes 0010, 0011, 0110 for resource shortage
// [R17] Cause 0101 for long errored packet
// [R18] Fill A first, then B, else drop
// [R19] Interrupt while a slot set and unmasked
`timescale 1ns/1ps
module sbdsr_top #(
  parameter int CNT_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] rate_drop_pulse,
  input wire logic drop_evt_valid,
  input wire logic [3:0] drop_evt_cause,
  input wire logic [1:0] drop_evt_port,
  output logic [11:0] port2_default_vid,
  output logic [2:0] port2_default_prio,
  output logic buf_irq
);
  if (CNT_W < 1 || CNT_W > 32) begin : g_chk
    $error("CNT_W must be 1 to 32");
  end

  // Write channel state
  logic aw_held_r, w_held_r;
  logic [15:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic awready_r, wready_r, bvalid_r;
  logic [1:0] bresp_r;

  // Read channel state
  logic arready_r, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Register contents
  logic [2:0] prio_r;
  logic [11:0] vid_r;
  logic mask_r;
  logic irq_r;

  wire logic aw_take = s_axi_awvalid && awready_r;
  wire logic w_take = s_axi_wvalid && wready_r;
  // Write commits once both halves are held and the previous response is gone
  wire logic wr_go = aw_held_r && w_held_r && !bvalid_r;
  wire logic aw_held_nxt = aw_take || (aw_held_r && !wr_go);
  wire logic w_held_nxt = w_take || (w_held_r && !wr_go);
  wire logic bvalid_nxt = wr_go || (bvalid_r && !s_axi_bready);
  wire logic rd_go = s_axi_arvalid && arready_r;
  wire logic rvalid_nxt = rd_go || (rvalid_r && !s_axi_rready);

  // Write decode
  wire logic wr_hit_tag = sbdsr_pkg::sbdsr_hit(aw_addr_r, sbdsr_pkg::IDX_P2_TAG);
  wire logic wr_hit_mask = sbdsr_pkg::sbdsr_hit(aw_addr_r, sbdsr_pkg::IDX_MASK);
  wire logic wr_hit_ro = sbdsr_pkg::sbdsr_hit(aw_addr_r, sbdsr_pkg::IDX_CNT0) ||
                         sbdsr_pkg::sbdsr_hit(aw_addr_r, sbdsr_pkg::IDX_CNT1) ||
                         sbdsr_pkg::sbdsr_hit(aw_addr_r, sbdsr_pkg::IDX_CNT2) ||
                         sbdsr_pkg::sbdsr_hit(aw_addr_r, sbdsr_pkg::IDX_STATUS);
  wire logic wr_mapped = wr_hit_tag || wr_hit_mask || wr_hit_ro;

  wire logic [31:0] tag_word = {17'h00000, prio_r, vid_r};
  wire logic [31:0] tag_merged = sbdsr_pkg::sbdsr_merge(tag_word, w_data_r, w_strb_r);
  wire logic [31:0] mask_merged = sbdsr_pkg::sbdsr_merge({31'h00000000, mask_r},
                                                         w_data_r, w_strb_r);

  // Read decode
  wire logic rd_hit_tag = sbdsr_pkg::sbdsr_hit(s_axi_araddr, sbdsr_pkg::IDX_P2_TAG);
  wire logic rd_hit_mask = sbdsr_pkg::sbdsr_hit(s_axi_araddr, sbdsr_pkg::IDX_MASK);
  wire logic rd_hit_status = sbdsr_pkg::sbdsr_hit(s_axi_araddr, sbdsr_pkg::IDX_STATUS);
  wire logic [2:0] rd_hit_cnt = {sbdsr_pkg::sbdsr_hit(s_axi_araddr, sbdsr_pkg::IDX_CNT2),
                                 sbdsr_pkg::sbdsr_hit(s_axi_araddr, sbdsr_pkg::IDX_CNT1),
                                 sbdsr_pkg::sbdsr_hit(s_axi_araddr, sbdsr_pkg::IDX_CNT0)};
  wire logic rd_mapped = rd_hit_tag || rd_hit_mask || rd_hit_status || (|rd_hit_cnt);

  // Drop counters, indexed by source port code
  logic [CNT_W-1:0] cnt_val [3];
  logic [31:0] cnt_word [3];
  for (genvar p = 0; p < 3; p++) begin : g_cnt
    sbdsr_drop_counter #(.CNT_W(CNT_W)) i_sbdsr_drop_counter (
      .aclk(aclk),
      .aresetn(aresetn),
      .inc(rate_drop_pulse[p]), // R3
      .rd_clr(rd_go && rd_hit_cnt[p]), // R4
      .count(cnt_val[p])
    );
    assign cnt_word[p] = 32'(cnt_val[p]);
  end

  // Drop event capture; the mask is deliberately not routed here
  sbdsr_evt_if evt_bus ();
  assign evt_bus.evt_valid = drop_evt_valid; // R7
  assign evt_bus.evt_cause = drop_evt_cause;
  assign evt_bus.evt_port = drop_evt_port;
  assign evt_bus.rd_clr = rd_go && rd_hit_status; // R9 R12

  sbdsr_event_capture i_sbdsr_event_capture (
    .aclk(aclk),
    .aresetn(aresetn),
    .ev(evt_bus)
  );

  wire logic slot_a_set = evt_bus.status[sbdsr_pkg::A_VALID_BIT];
  wire logic slot_b_set = evt_bus.status[sbdsr_pkg::B_PEND_BIT];

  wire logic [31:0] rd_word =
    rd_hit_tag ? tag_word :
    rd_hit_cnt[0] ? cnt_word[0] :
    rd_hit_cnt[1] ? cnt_word[1] :
    rd_hit_cnt[2] ? cnt_word[2] :
    rd_hit_mask ? {31'h00000000, mask_r} :
    rd_hit_status ? 32'(evt_bus.status) : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= sbdsr_pkg::RESP_OKAY;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awready_r <= !aw_held_nxt;
      wready_r <= !w_held_nxt;
      bvalid_r <= bvalid_nxt;
      if (wr_go) begin
        bresp_r <= wr_mapped ? sbdsr_pkg::RESP_OKAY : sbdsr_pkg::RESP_SLVERR;
      end
    end
  end

  // Payload registers need no reset; they are only used while held
  always_ff @(posedge aclk) begin
    if (aw_take) begin
      aw_addr_r <= s_axi_awaddr;
    end
    if (w_take) begin
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prio_r <= sbdsr_pkg::PRIO_RST; // R1
      vid_r <= sbdsr_pkg::VID_RST; // R2
      mask_r <= sbdsr_pkg::MASK_RST; // R6
    end else begin
      if (wr_go && wr_hit_tag) begin
        prio_r <= tag_merged[sbdsr_pkg::PRIO_LSB +: sbdsr_pkg::PRIO_W]; // R1
        vid_r <= tag_merged[sbdsr_pkg::VID_LSB +: sbdsr_pkg::VID_W]; // R2
      end
      if (wr_go && wr_hit_mask) begin
        mask_r <= mask_merged[sbdsr_pkg::MASK_BIT]; // R6
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= sbdsr_pkg::RESP_OKAY;
      irq_r <= 1'b0;
    end else begin
      arready_r <= !rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (rd_go) begin
        rdata_r <= rd_word;
        rresp_r <= rd_mapped ? sbdsr_pkg::RESP_OKAY : sbdsr_pkg::RESP_SLVERR;
      end
      irq_r <= (slot_a_set || slot_b_set) && !mask_r; // R19 R6
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign port2_default_prio = prio_r;
  assign port2_default_vid = vid_r;
  assign buf_irq = irq_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  prio_write_a: assert property (wr_go && wr_hit_tag && w_strb_r[1] |=> port2_default_prio == $past(w_data_r[14:12])) else $error("default priority not written"); // R1
  vid_write_a: assert property (wr_go && wr_hit_tag && (&w_strb_r[1:0]) |=> port2_default_vid == $past(w_data_r[11:0])) else $error("default VLAN ID not written"); // R2
  cnt_read_clr_a: assert property (rd_go && rd_hit_cnt[0] && !rate_drop_pulse[0] |=> cnt_val[0] == '0) else $error("port 0 counter not cleared by read"); // R4
  cnt_read_val_a: assert property (rd_go && rd_hit_cnt[1] |=> s_axi_rvalid && s_axi_rdata == $past(cnt_word[1])) else $error("port 1 counter read wrong"); // R3
  mask_block_a: assert property (mask_r |=> !buf_irq) else $error("interrupt raised while masked"); // R6
  irq_raise_a: assert property ((slot_a_set || slot_b_set) && !mask_r |=> buf_irq) else $error("unmasked drop event gave no interrupt"); // R19
  mask_no_touch_a: assert property (wr_go && wr_hit_mask && !drop_evt_valid && !evt_bus.rd_clr |=> $stable(evt_bus.status)) else $error("mask write altered drop status"); // R7
  status_read_a: assert property (rd_go && rd_hit_status && !drop_evt_valid |=> s_axi_rdata == 32'($past(evt_bus.status)) ##0 evt_bus.status == '0) else $error("status read or clear wrong"); // R9 R12
  slot_b_cause_a: assert property (drop_evt_valid && slot_a_set && !slot_b_set && !evt_bus.rd_clr |=> evt_bus.status[13:10] == $past(drop_evt_cause) && evt_bus.status[9:8] == $past(drop_evt_port)) else $error("slot B fields wrong"); // R13 R11
  slot_a_cause_a: assert property (drop_evt_valid && !slot_a_set |=> evt_bus.status[6:3] == $past(drop_evt_cause)) else $error("slot A cause wrong"); // R10
  full_drop_a: assert property (drop_evt_valid && slot_a_set && slot_b_set && !evt_bus.rd_clr |=> $stable(evt_bus.status)) else $error("event overwrote a full slot"); // R18
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped before rready");
  bresp_time_a: assert property (wr_go |=> s_axi_bvalid) else $error("write response late");

  both_slots_c: cover property (slot_a_set && slot_b_set ##1 rd_go && rd_hit_status);
  irq_rise_c: cover property (!buf_irq ##1 buf_irq);
  tag_write_c: cover property (wr_go && wr_hit_tag);
  clear_race_c: cover property (evt_bus.rd_clr && drop_evt_valid);
endmodule

// ---- common/sbdsr_pkg.sv ----
// Shared constants and types for the switch buffer drop status register block.
// Assumes AXI4-Lite with 32-bit data; registers sit at four times their index.
package sbdsr_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // Register indices; byte address is the index times four
  localparam logic [13:0] IDX_P2_TAG = 14'h1c15;
  localparam logic [13:0] IDX_CNT0 = 14'h1c16;
  localparam logic [13:0] IDX_CNT1 = 14'h1c17;
  localparam logic [13:0] IDX_CNT2 = 14'h1c18;
  localparam logic [13:0] IDX_MASK = 14'h1c20;
  localparam logic [13:0] IDX_STATUS = 14'h1c21;

  // Port 2 default tag fields
  localparam int PRIO_LSB = 12;
  localparam int PRIO_W = 3;
  localparam int VID_LSB = 0;
  localparam int VID_W = 12;
  localparam logic [2:0] PRIO_RST = 3'h0;
  localparam logic [11:0] VID_RST = 12'h000;

  // Interrupt mask
  localparam int MASK_BIT = 0;
  localparam logic MASK_RST = 1'b1;

  // Drop counters
  localparam logic [31:0] CNT_RST = 32'h00000000;

  // Drop status layout
  localparam int A_VALID_BIT = 0;
  localparam int A_PORT_LSB = 1;
  localparam int A_CAUSE_LSB = 3;
  localparam int B_PEND_BIT = 7;
  localparam int B_PORT_LSB = 8;
  localparam int B_CAUSE_LSB = 10;
  localparam int STATUS_W = 14;
  localparam logic [13:0] STATUS_RST = 14'h0000;

  typedef logic [3:0] sbdsr_cause_t;
  typedef logic [1:0] sbdsr_port_t;

  localparam sbdsr_cause_t CAUSE_BCAST_LEVEL = 4'h0; // R14
  localparam sbdsr_cause_t CAUSE_RED = 4'h1; // R15
  localparam sbdsr_cause_t CAUSE_NO_BUF = 4'h2; // R16
  localparam sbdsr_cause_t CAUSE_NO_DESC = 4'h3; // R16
  localparam sbdsr_cause_t CAUSE_NO_DEST = 4'h4; // R14
  localparam sbdsr_cause_t CAUSE_RX_ERR = 4'h5; // R17
  localparam sbdsr_cause_t CAUSE_DROP_LEVEL = 4'h6; // R16
  localparam sbdsr_cause_t CAUSE_YELLOW = 4'h9; // R15

  localparam sbdsr_port_t PORT0 = 2'h0; // R11
  localparam sbdsr_port_t PORT1 = 2'h1; // R11
  localparam sbdsr_port_t PORT2 = 2'h2; // R11

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic sbdsr_hit(input logic [15:0] addr, input logic [13:0] idx);
    return addr[15:2] == idx;
  endfunction

  function automatic logic [31:0] sbdsr_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction
endpackage

// ---- common/sbdsr_evt_if.sv ----
// Carrier between the register core and the drop event capture slots.
// All signals are on the core clock; no crossing here.
`timescale 1ns/1ps
interface sbdsr_evt_if;
  logic evt_valid;
  sbdsr_pkg::sbdsr_cause_t evt_cause;
  sbdsr_pkg::sbdsr_port_t evt_port;
  logic rd_clr;
  logic [13:0] status;

  modport core (output evt_valid, output evt_cause, output evt_port, output rd_clr,
                input status);
  modport capture (input evt_valid, input evt_cause, input evt_port, input rd_clr,
                   output status);
endinterface

// ---- logic/sbdsr_drop_counter.sv ----
// Saturating drop counter that clears when software reads it.
// Assumes inc and rd_clr are one-cycle pulses on aclk.
`timescale 1ns/1ps
module sbdsr_drop_counter #(
  parameter int CNT_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic inc,
  input wire logic rd_clr,
  output logic [CNT_W-1:0] count
);
  if (CNT_W < 1 || CNT_W > 32) begin : g_chk
    $error("CNT_W must be 1 to 32");
  end

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  wire logic at_max = &count_r;

  // A drop in the read cycle is kept: the read saw the old value
  assign count_nxt = rd_clr ? (inc ? CNT_W'(1) : '0) : // R4
                     (inc && !at_max) ? count_r + CNT_W'(1) : count_r; // R3 R5

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= CNT_W'(sbdsr_pkg::CNT_RST); // R4
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  cnt_step_a: assert property (inc && !rd_clr && !at_max |=> count_r == $past(count_r) + CNT_W'(1)) else $error("counter missed a drop"); // R3
  cnt_sat_a: assert property (at_max && !rd_clr |=> &count_r) else $error("counter wrapped at maximum"); // R5
  cnt_clr_a: assert property (rd_clr && !inc |=> count_r == '0) else $error("counter not cleared by read"); // R4
endmodule

// ---- logic/sbdsr_event_capture.sv ----
// Two capture slots for drop events, cleared together when status is read.
// Assumes evt_valid is a one-cycle pulse per dropped packet.
`timescale 1ns/1ps
module sbdsr_event_capture (
  input wire logic aclk,
  input wire logic aresetn,
  sbdsr_evt_if.capture ev
);
  logic a_valid_r, b_pend_r;
  sbdsr_pkg::sbdsr_cause_t a_cause_r, b_cause_r;
  sbdsr_pkg::sbdsr_port_t a_port_r, b_port_r;

  // A slot being read this cycle counts as free, so an event never loses to the clear
  wire logic a_keep = a_valid_r && !ev.rd_clr;
  wire logic b_keep = b_pend_r && !ev.rd_clr;
  wire logic fill_a = ev.evt_valid && !a_keep; // R18
  wire logic fill_b = ev.evt_valid && a_keep && !b_keep; // R18 R8

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_valid_r <= 1'b0;
      b_pend_r <= 1'b0;
      a_cause_r <= '0;
      b_cause_r <= '0;
      a_port_r <= '0;
      b_port_r <= '0;
    end else begin
      a_valid_r <= fill_a || a_keep; // R9
      b_pend_r <= fill_b || b_keep; // R12
      // Codes are stored as delivered, reserved ones included
      a_cause_r <= fill_a ? ev.evt_cause : (a_keep ? a_cause_r : '0); // R10 R14 R15 R16 R17
      a_port_r <= fill_a ? ev.evt_port : (a_keep ? a_port_r : '0); // R11
      b_cause_r <= fill_b ? ev.evt_cause : (b_keep ? b_cause_r : '0); // R13
      b_port_r <= fill_b ? ev.evt_port : (b_keep ? b_port_r : '0); // R11
    end
  end

  assign ev.status = {b_cause_r, b_port_r, b_pend_r, a_cause_r, a_port_r, a_valid_r};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  slot_a_fill_a: assert property (ev.evt_valid && !a_valid_r |=> a_valid_r && a_cause_r == $past(ev.evt_cause) && a_port_r == $past(ev.evt_port)) else $error("slot A not filled"); // R18
  slot_b_fill_a: assert property (ev.evt_valid && a_valid_r && !b_pend_r && !ev.rd_clr |=> b_pend_r && a_valid_r && b_cause_r == $past(ev.evt_cause)) else $error("slot B not filled"); // R8
  slot_clear_a: assert property (ev.rd_clr && !ev.evt_valid |=> ev.status == '0) else $error("status not cleared by read"); // R9
endmodule

// ---- verif/test_switch_buffer_drop_status_regs.sv ----
// Self-checking bench for the switch buffer drop status register block.
// Assumes sbdsr_pkg compiled first; drives AXI4-Lite and drop strobes itself.
`timescale 1ns/1ps
module test_switch_buffer_drop_status_regs;
  logic aclk, aresetn;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot, rate_drop_pulse, port2_default_prio;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, drop_evt_valid, buf_irq;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, drop_evt_cause;
  logic [1:0] s_axi_bresp, s_axi_rresp, drop_evt_port;
  logic [11:0] port2_default_vid;
  int error_cnt = 0;
  int checks_done = 0;
  localparam logic [1:0] OK = sbdsr_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = sbdsr_pkg::RESP_SLVERR;

  // Narrow counters so saturation is reached in a few pulses
  sbdsr_top #(.CNT_W(4)) i_sbdsr_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rate_drop_pulse(rate_drop_pulse),
    .drop_evt_valid(drop_evt_valid), .drop_evt_cause(drop_evt_cause),
    .drop_evt_port(drop_evt_port), .port2_default_vid(port2_default_vid),
    .port2_default_prio(port2_default_prio), .buf_irq(buf_irq));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  function automatic logic [15:0] ba(input logic [13:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er, input string m);
    bit ad, wd, bd;
    ad = 0;
    wd = 0;
    bd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Only the watchdog ends a wait for the answer
    while (!bd) begin
      @(posedge aclk);
      if (ad && wd && s_axi_bvalid === 1'b1) begin
        bd = 1;
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp === er, m);
      end
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask

  task automatic axi_read(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er,
                          input string m);
    bit ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!dd) begin
      @(posedge aclk);
      if (ad && s_axi_rvalid === 1'b1) begin
        dd = 1;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata === ed && s_axi_rresp === er, m);
      end
      if (!ad && s_axi_arready === 1'b1) begin
        ad = 1;
        s_axi_arvalid <= 1'b0;
      end
    end
  endtask

  task automatic drop_evt(input logic [3:0] c, input logic [1:0] p);
    @(posedge aclk);
    drop_evt_valid <= 1'b1;
    drop_evt_cause <= c;
    drop_evt_port <= p;
    @(posedge aclk);
    drop_evt_valid <= 1'b0;
  endtask

  task automatic rate(input logic [2:0] m, input int n);
    repeat (n) begin
      @(posedge aclk);
      rate_drop_pulse <= m;
      @(posedge aclk);
      rate_drop_pulse <= 3'h0;
    end
  endtask

  task automatic test_reset();
    chk(port2_default_vid === 12'h000 && port2_default_prio === 3'h0, "tag outputs");
    axi_read(ba(sbdsr_pkg::IDX_P2_TAG), 32'h00000000, OK, "tag reset");
    axi_read(ba(sbdsr_pkg::IDX_CNT0), 32'h00000000, OK, "cnt0 reset");
    axi_read(ba(sbdsr_pkg::IDX_MASK), 32'h00000001, OK, "mask reset");
    axi_read(ba(sbdsr_pkg::IDX_STATUS), 32'h00000000, OK, "status reset");
    $display("test reset done");
  endtask

  task automatic test_tag();
    axi_write(ba(sbdsr_pkg::IDX_P2_TAG), 32'hffffffff, 4'hf, OK, "tag write");
    axi_read(ba(sbdsr_pkg::IDX_P2_TAG), 32'h00007fff, OK, "tag all ones");
    chk(port2_default_vid === 12'hfff && port2_default_prio === 3'h7, "tag out");
    axi_write(ba(sbdsr_pkg::IDX_P2_TAG), 32'h00000000, 4'h1, OK, "tag byte write");
    axi_read(ba(sbdsr_pkg::IDX_P2_TAG), 32'h00007f00, OK, "tag byte lane");
    chk(port2_default_vid === 12'hf00 && port2_default_prio === 3'h7, "tag out lane");
    axi_write(16'h7000, 32'h12345678, 4'hf, ERR, "unmapped write");
    axi_read(16'h7000, 32'h00000000, ERR, "unmapped read");
    $display("test tag done");
  endtask

  task automatic test_counters();
    rate(3'b111, 3);
    rate(3'b101, 2);
    rate(3'b001, 12);
    axi_write(ba(sbdsr_pkg::IDX_CNT1), 32'hffffffff, 4'hf, OK, "counter write");
    axi_read(ba(sbdsr_pkg::IDX_CNT0), 32'h0000000f, OK, "cnt0 saturated");
    axi_read(ba(sbdsr_pkg::IDX_CNT1), 32'h00000003, OK, "cnt1 value");
    axi_read(ba(sbdsr_pkg::IDX_CNT2), 32'h00000005, OK, "cnt2 value");
    axi_read(ba(sbdsr_pkg::IDX_CNT0), 32'h00000000, OK, "cnt0 cleared");
    axi_read(ba(sbdsr_pkg::IDX_CNT1), 32'h00000000, OK, "cnt1 cleared");
    axi_read(ba(sbdsr_pkg::IDX_CNT2), 32'h00000000, OK, "cnt2 cleared");
    $display("test counters done");
  endtask

  task automatic test_mask();
    drop_evt(sbdsr_pkg::CAUSE_RED, sbdsr_pkg::PORT1);
    repeat (3) @(posedge aclk);
    chk(buf_irq === 1'b0, "irq while masked");
    axi_write(ba(sbdsr_pkg::IDX_MASK), 32'h00000000, 4'hf, OK, "unmask");
    repeat (2) @(posedge aclk);
    chk(buf_irq === 1'b1, "irq unmasked");
    axi_write(ba(sbdsr_pkg::IDX_MASK), 32'h00000001, 4'hf, OK, "mask again");
    repeat (2) @(posedge aclk);
    chk(buf_irq === 1'b0, "irq masked again");
    axi_read(ba(sbdsr_pkg::IDX_STATUS), 32'h0000000b, OK, "masked capture");
    axi_write(ba(sbdsr_pkg::IDX_MASK), 32'h00000000, 4'hf, OK, "unmask idle");
    repeat (2) @(posedge aclk);
    chk(buf_irq === 1'b0, "no irq when empty");
    $display("test mask done");
  endtask

  task automatic test_events();
    logic [3:0] cs [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
    logic [3:0] ca, cb;
    logic [1:0] pa, pb;
    for (int i = 0; i < 8; i++) begin
      ca = cs[i];
      cb = cs[(i + 1) % 8];
      pa = 2'(i % 3);
      pb = 2'((i + 1) % 3);
      drop_evt(ca, pa);
      drop_evt(cb, pb);
      drop_evt(4'hf, 2'h3);
      axi_read(ba(sbdsr_pkg::IDX_STATUS), {18'h0, cb, pb, 1'b1, ca, pa, 1'b1}, OK,
               "two slots");
      axi_read(ba(sbdsr_pkg::IDX_STATUS), 32'h00000000, OK, "status cleared");
    end
    $display("test events done");
  endtask

  // A read and a new drop on the same edge: the read sees the old value, the drop is kept
  task automatic test_race();
    rate(3'b010, 2);
    fork
      axi_read(ba(sbdsr_pkg::IDX_CNT1), 32'h00000002, OK, "cnt1 read in drop");
      rate(3'b010, 1);
    join
    axi_read(ba(sbdsr_pkg::IDX_CNT1), 32'h00000001, OK, "drop kept over clear");
    drop_evt(sbdsr_pkg::CAUSE_RED, sbdsr_pkg::PORT0);
    fork
      axi_read(ba(sbdsr_pkg::IDX_STATUS), 32'h00000009, OK, "status read in event");
      drop_evt(sbdsr_pkg::CAUSE_NO_BUF, sbdsr_pkg::PORT2);
    join
    axi_read(ba(sbdsr_pkg::IDX_STATUS), 32'h00000015, OK, "event kept over clear");
    $display("test race done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end

  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awprot, s_axi_arprot, rate_drop_pulse, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {drop_evt_valid, drop_evt_cause, drop_evt_port} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset();
    test_tag();
    test_counters();
    test_mask();
    test_events();
    test_race();
    complete_run();
  end
endmodule
